// file: pss_bridge_model.sv
// Bridge power stage model: resolves pin levels and reports overcurrent
`timescale 1ns/1ps
module pss_bridge_model (
  input  wire logic       sys_clk,
  input  wire logic [3:0] pwm_out,
  input  wire logic [3:0] pwm_oe_n,
  input  wire logic       overload,
  output logic [3:0]      pin_lvl,
  output logic            sense_trip
);
  logic [3:0] flip_q = 4'h5;

  // Released gates float; a changing pattern keeps stale levels from passing
  always_ff @(posedge sys_clk)
    flip_q <= ~flip_q;

  // Driven pin shows the block's value, else the floating pattern
  always_comb
    for (int i = 0; i < 4; i++)
      pin_lvl[i] = pwm_oe_n[i] ? flip_q[i] : pwm_out[i];

  // Current sense comparator trips only on a commanded overload
  assign sense_trip = overload;
endmodule // pss_bridge_model

// file: pss_pkg.sv
// Shared constants for the PWM shutdown and steering block
package pss_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_SHUTDOWN = 12'h000;
  localparam logic [11:0] ADDR_RESTART  = 12'h004;
  localparam logic [11:0] ADDR_STEERING = 12'h008;
  localparam logic [11:0] ADDR_MODE     = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SD_FLAG_BIT   = 7;  // shutdown_active_flag
  localparam int SD_SRC_LSB    = 4;  // shutdown_source_select, 3 bits
  localparam int SD_AC_LSB     = 2;  // ac_shutdown_level, 2 bits
  localparam int SD_BD_LSB     = 0;  // bd_shutdown_level, 2 bits
  localparam int RS_AUTO_BIT   = 7;  // auto_restart_enable
  localparam int RS_DELAY_LSB  = 0;  // dead_delay_count, 7 bits
  localparam int ST_SYNC_BIT   = 4;  // steer_sync
  localparam int ST_EN_LSB     = 0;  // steer_enable_a..d, 4 bits
  localparam int MD_CCP_LSB    = 0;  // ccp_mode_select, 4 bits
  localparam int MD_BRIDGE_LSB = 4;  // bridge_config, 2 bits
  localparam int MD_CSYNC_BIT  = 6;  // comparator_sync
  localparam int IRQ_SD_BIT    = 0;  // Shutdown entered
  localparam int IRQ_RS_BIT    = 1;  // Shutdown left

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SHUTDOWN = 8'h00;
  localparam logic [7:0] RST_RESTART  = 8'h00;
  localparam logic [4:0] RST_STEERING = 5'h01;
  localparam logic [6:0] RST_MODE     = 7'h00;
  localparam logic [1:0] RST_IRQ      = 2'h0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] CCP_PWM     = 2'h3;  // Upper mode bits for PWM
  localparam logic [1:0] BR_SINGLE   = 2'h0;
  localparam logic [1:0] BR_FULL_FWD = 2'h1;
  localparam logic [1:0] BR_HALF     = 2'h2;
  localparam logic [1:0] BR_FULL_REV = 2'h3;

endpackage

// file: pss_top.sv
// PWM output stage: auto-shutdown, restart, dead delay and steering
// Notes on behaviour
// - Source select 000 disables; bits pick comparator 1, comparator 2, low pin.
// - In shutdown a/c pins go low, high, or tri-state by their level field.
// - In shutdown b/d pins go low, high, or tri-state by their level field.
// - With the shutdown flag clear outputs run normally without override.
// - With auto restart on, the flag clears once the source goes away.
// - Each inactive-to-active edge waits dead_delay_count sys_clk cycles.
// - Steering changes apply at period start if synced, else next cycle.
// - Steered pin carries PWM with mode polarity; unsteered pin is a port pin.
// - Steering counts only in PWM mode with bridge_config 00.
// - With comparator sync, comparator shutdown waits for the Timer1 tick.
// - Reset clears control bits except steer_enable_a; steering bits 7-5 read 0.
// - Mode low bits pick active-low per a/c pair and per b/d pair.
// - Bridge config picks single, full forward, half with dead band, full reverse.
`timescale 1ns/1ps
module pss_top #(
  parameter int DELAY_W = 7
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pwm_in,
  input  wire logic        period_start,
  input  wire logic        timer1_tick,
  input  wire logic        cmp1_in,
  input  wire logic        cmp2_in,
  input  wire logic        ext_irq_pin,
  input  wire logic [3:0]  port_data,
  input  wire logic [3:0]  port_oe_n,
  output logic [3:0]       pwm_out,
  output logic [3:0]       pwm_oe_n,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [7:0]         sd_ctl_q;
  logic [7:0]         rs_ctl_q;
  logic [4:0]         st_ctl_q;
  logic [6:0]         mode_q;
  logic [1:0]         ist_q;
  logic [1:0]         imask_q;
  logic [31:0]        prdata_q;
  logic               sd_d;
  logic               sd_q;
  logic               wr_en;
  logic               rd_done;
  logic               mapped;
  logic [1:0]         ev;

  assign wr_en   = psel & penable & pwrite;
  assign rd_done = psel & penable & ~pwrite;
  assign pready  = 1'b1;  // Zero wait states
  assign mapped  = (paddr == pss_pkg::ADDR_SHUTDOWN) | (paddr == pss_pkg::ADDR_RESTART) |
                   (paddr == pss_pkg::ADDR_STEERING) | (paddr == pss_pkg::ADDR_MODE) |
                   (paddr == pss_pkg::ADDR_IRQ_STAT) | (paddr == pss_pkg::ADDR_IRQ_MASK);
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_q;

  // Read data captured in the setup cycle, presented in the access cycle
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      prdata_q <= 32'h0000_0000;
    else if (psel & ~penable)
      case (paddr)
        pss_pkg::ADDR_SHUTDOWN: prdata_q <= {24'h00_0000, sd_q, sd_ctl_q[6:0]};
        pss_pkg::ADDR_RESTART:  prdata_q <= {24'h00_0000, rs_ctl_q};
        pss_pkg::ADDR_STEERING: prdata_q <= {27'h000_0000, st_ctl_q};
        pss_pkg::ADDR_MODE:     prdata_q <= {25'h000_0000, mode_q};
        pss_pkg::ADDR_IRQ_STAT: prdata_q <= {30'h0000_0000, ist_q | ev}; // Same-edge event kept
        pss_pkg::ADDR_IRQ_MASK: prdata_q <= {30'h0000_0000, imask_q};
        default:                prdata_q <= 32'h0000_0000;
      endcase

  // Control registers; the flag bit of sd_ctl_q is unused, sd_q holds it
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      sd_ctl_q <= pss_pkg::RST_SHUTDOWN;
      rs_ctl_q <= pss_pkg::RST_RESTART;
      st_ctl_q <= pss_pkg::RST_STEERING;
      mode_q   <= pss_pkg::RST_MODE;
      imask_q  <= pss_pkg::RST_IRQ;
    end
    else if (wr_en)
      case (paddr)
        pss_pkg::ADDR_SHUTDOWN: sd_ctl_q <= {1'b0, pwdata[6:0]};
        pss_pkg::ADDR_RESTART:  rs_ctl_q <= pwdata[7:0];
        pss_pkg::ADDR_STEERING: st_ctl_q <= pwdata[4:0];
        pss_pkg::ADDR_MODE:     mode_q   <= pwdata[6:0];
        pss_pkg::ADDR_IRQ_MASK: imask_q  <= pwdata[1:0];
        default:                ;
      endcase

  // Field aliases
  logic [2:0]         src_sel;
  logic [1:0]         ac_lvl;
  logic [1:0]         bd_lvl;
  logic               auto_rs;
  logic [DELAY_W-1:0] dly_cnt;
  logic [1:0]         bridge;
  logic               pwm_mode;
  logic               csync;
  assign src_sel  = sd_ctl_q[pss_pkg::SD_SRC_LSB +: 3];
  assign ac_lvl   = sd_ctl_q[pss_pkg::SD_AC_LSB +: 2];
  assign bd_lvl   = sd_ctl_q[pss_pkg::SD_BD_LSB +: 2];
  assign auto_rs  = rs_ctl_q[pss_pkg::RS_AUTO_BIT];
  assign dly_cnt  = rs_ctl_q[pss_pkg::RS_DELAY_LSB +: DELAY_W];
  assign bridge   = mode_q[pss_pkg::MD_BRIDGE_LSB +: 2];
  assign pwm_mode = (mode_q[pss_pkg::MD_CCP_LSB + 2 +: 2] == pss_pkg::CCP_PWM);
  assign csync    = mode_q[pss_pkg::MD_CSYNC_BIT];

  // ----------------------------------------------------------------
  // Shutdown sources
  // ----------------------------------------------------------------
  // Pins pass three flops; a level counts once stages two and three agree
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] lvl_q;
  logic [1:0] cmp_t1_q;
  logic [2:0] src_vec;
  logic       src;

  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      s1_q  <= 3'h4;
      s2_q  <= 3'h4;
      s3_q  <= 3'h4;
      lvl_q <= 3'h4;  // External pin idles high
    end
    else
    begin
      s1_q  <= {ext_irq_pin, cmp2_in, cmp1_in};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
    end

  // Comparator levels resampled on the Timer1 tick
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      cmp_t1_q <= 2'h0;
    else if (timer1_tick)
      cmp_t1_q <= lvl_q[1:0];

  // Each select bit enables one source, so 000 means none
  assign src_vec = {~lvl_q[2], (csync ? cmp_t1_q : lvl_q[1:0])};
  assign src     = |(src_sel & src_vec);

  // ----------------------------------------------------------------
  // Shutdown flag and restart
  // ----------------------------------------------------------------
  logic sw_wr_sd;
  assign sw_wr_sd = wr_en & (paddr == pss_pkg::ADDR_SHUTDOWN);

  // A live source always wins over a software or automatic clear
  always_comb
  begin
    sd_d = sd_q;
    if (auto_rs & ~src)
      sd_d = 1'b0;
    if (sw_wr_sd)
      sd_d = pwdata[pss_pkg::SD_FLAG_BIT];
    if (src)
      sd_d = 1'b1;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      sd_q <= 1'b0;
    else
      sd_q <= sd_d;

  // Sticky events cleared by status read; a new event beats the clear
  assign ev = {sd_q & ~sd_d, sd_d & ~sd_q};
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      ist_q <= pss_pkg::RST_IRQ;
    else if (rd_done & (paddr == pss_pkg::ADDR_IRQ_STAT))
      ist_q <= ev;
    else
      ist_q <= ist_q | ev;

  assign irq = |(ist_q & imask_q);

  // ----------------------------------------------------------------
  // Steering and bridge decode
  // ----------------------------------------------------------------
  logic [3:0] str_eff_q;
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      str_eff_q <= pss_pkg::RST_STEERING[3:0];
    else if (~st_ctl_q[pss_pkg::ST_SYNC_BIT] | period_start)
      str_eff_q <= st_ctl_q[pss_pkg::ST_EN_LSB +: 4];

  // Desired active state and pin ownership per pin, index 0 is pin a
  logic [3:0] act;
  logic [3:0] own;
  always_comb
  begin
    act = 4'h0;
    own = 4'h0;
    case (bridge)
      pss_pkg::BR_SINGLE:
      begin
        act = {4{pwm_in}};
        own = str_eff_q;
      end
      pss_pkg::BR_FULL_FWD:
      begin
        act = {pwm_in, 3'b001};
        own = 4'hf;
      end
      pss_pkg::BR_HALF:
      begin
        act = {2'b00, ~pwm_in, pwm_in};
        own = 4'h3;
      end
      pss_pkg::BR_FULL_REV:
      begin
        act = {1'b0, 1'b1, pwm_in, 1'b0};
        own = 4'hf;
      end
      default:
      begin
        act = 4'h0;
        own = 4'h0;
      end
    endcase
    if (~pwm_mode)
      own = 4'h0;
  end

  // ----------------------------------------------------------------
  // Per-pin dead delay and output drive
  // ----------------------------------------------------------------
  logic [DELAY_W-1:0] cnt_q [4];
  logic [3:0]         dly_q;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pin
      logic [1:0] sd_lvl;
      logic       pol_low;
      assign sd_lvl  = (gi % 2 == 0) ? ac_lvl : bd_lvl;
      assign pol_low = (gi % 2 == 0) ? mode_q[pss_pkg::MD_CCP_LSB + 1]
                                     : mode_q[pss_pkg::MD_CCP_LSB];

      // Only the rising edge waits; falling edges pass at once
      always_ff @(posedge sys_clk or posedge sys_rst)
        if (sys_rst)
        begin
          cnt_q[gi] <= '0;
          dly_q[gi] <= 1'b0;
        end
        else if (~act[gi])
        begin
          cnt_q[gi] <= '0;
          dly_q[gi] <= 1'b0;
        end
        else if (~dly_q[gi])
        begin
          cnt_q[gi] <= cnt_q[gi] + 1'b1;
          dly_q[gi] <= (cnt_q[gi] >= dly_cnt);
        end

      // Registered pins: shutdown override, then PWM, then port control
      always_ff @(posedge sys_clk or posedge sys_rst)
        if (sys_rst)
        begin
          pwm_out[gi]  <= 1'b0;
          pwm_oe_n[gi] <= 1'b1;
        end
        else if (sd_q)
        begin
          pwm_out[gi]  <= sd_lvl[0] & ~sd_lvl[1];
          pwm_oe_n[gi] <= sd_lvl[1];
        end
        else if (own[gi])
        begin
          pwm_out[gi]  <= dly_q[gi] ^ pol_low;
          pwm_oe_n[gi] <= 1'b0;
        end
        else
        begin
          pwm_out[gi]  <= port_data[gi];
          pwm_oe_n[gi] <= port_oe_n[gi];
        end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_src_sets_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
    src |=> sd_q ##1 (pwm_oe_n[0] == ac_lvl[1]))
    else $error("shutdown source did not force shutdown");

  chk_ac_drive_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sd_q && ac_lvl == 2'h0) |=> (pwm_out[0] == 1'b0 && pwm_oe_n[2] == 1'b0))
    else $error("a/c pins not driven low in shutdown");

  chk_bd_drive_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sd_q && bd_lvl == 2'h1) |=> (pwm_out[1] && pwm_out[3] && !pwm_oe_n[3]))
    else $error("b/d pins not driven high in shutdown");

  chk_ac_tristate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sd_q && ac_lvl[1]) |=> (pwm_oe_n[0] && pwm_oe_n[2]))
    else $error("a/c pins not released in shutdown");

  chk_auto_restart: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sd_q && auto_rs && !src && !sw_wr_sd) |=> !sd_q)
    else $error("auto restart did not clear shutdown");

  chk_manual_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sd_q && !auto_rs && !sw_wr_sd) |=> sd_q)
    else $error("shutdown cleared without software");

  chk_dead_delay: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(dly_q[0]) |-> ($past(cnt_q[0]) >= $past(dly_cnt) && $past(act[0])))
    else $error("active edge came before dead delay");

  chk_steer_sync: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_ctl_q[pss_pkg::ST_SYNC_BIT] && !period_start) |=> $stable(str_eff_q))
    else $error("steering changed outside period start");

  chk_no_pwm_mode: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!pwm_mode && !sd_q) |=> (pwm_oe_n == $past(port_oe_n)))
    else $error("pins not under port control outside PWM mode");

  chk_sync_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (csync && !timer1_tick) |=> $stable(cmp_t1_q))
    else $error("synced comparator changed without Timer1 tick");

endmodule // pss_top

// file: tb.sv
// Self-checking bench for the PWM shutdown and steering block
`timescale 1ns/1ps
module tb;
  logic        sys_clk = 1'b0, sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'd17677;
  logic        pready, pslverr, irq, sense_trip, pin_smp = 1'b0;
  logic        pwm_in = 1'b0, period_start = 1'b0, cmp2_in = 1'b0, ext_irq_pin = 1'b1;
  logic        overload = 1'b0, timer1_tick = 1'b0;
  logic [3:0]  port_data = 4'h0, port_oe_n = 4'hf, pwm_out, pwm_oe_n, pin_lvl, pd, po;
  logic [32:0] rd_q[$];
  logic [12:0] pin_q[$], pe;
  int          errors = 0, tests_run = 0, n, d;

  pss_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_in(pwm_in), .period_start(period_start), .timer1_tick(timer1_tick),
    .cmp1_in(sense_trip), .cmp2_in(cmp2_in), .ext_irq_pin(ext_irq_pin),
    .port_data(port_data), .port_oe_n(port_oe_n), .pwm_out(pwm_out),
    .pwm_oe_n(pwm_oe_n), .irq(irq));
  pss_bridge_model i_bridge (.sys_clk(sys_clk), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n),
    .overload(overload), .pin_lvl(pin_lvl), .sense_trip(sense_trip));

  always #25 sys_clk = ~sys_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic cmp(string what, logic [39:0] exp, logic [39:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // APB transfer; the wait on pready is bounded so a hang ends the run
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] dat);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      errors++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] dat);
    apb(1'b1, a, dat);
  endtask

  task automatic rd(logic [11:0] a, logic [31:0] exp, logic err = 1'b0);
    rd_q.push_back({err, exp});
    apb(1'b0, a, 32'h0);
  endtask

  // Note the expected pins; the watcher compares them one edge later
  task automatic pins(logic [3:0] o, logic [3:0] oe, logic iq, logic [3:0] m = 4'hf);
    pin_q.push_back({m, iq, oe, o & m});
    pin_smp <= 1'b1;
    @(posedge sys_clk);
    pin_smp <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic idle(int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // Output seen at edge k is what the design launched at edge k-1
  task automatic edges(logic v);
    pwm_in <= v;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pwm_out[0] !== v && n < 300);
    if (pwm_out[0] !== v)
    begin
      errors++;
      finish_test();
    end
  endtask

  // Watcher: takes the oldest note whenever a read completes or pins are due
  always @(posedge sys_clk)
  begin
    if (psel && penable && pready && !pwrite && rd_q.size() > 0)
      cmp("read data", 40'(rd_q.pop_front()), 40'({pslverr, prdata}));
    if (pin_smp && pin_q.size() > 0)
    begin
      pe = pin_q.pop_front();
      cmp("pins", 40'(pe[8:0]), 40'({irq, pwm_oe_n, pwm_out & pe[12:9]}));
    end
  end

  initial
  begin
    idle(5);
    sys_rst <= 1'b0;
    port_data <= 4'(rnd());
    port_oe_n <= 4'(rnd());
    idle(3);
    pd = port_data;
    po = port_oe_n;
    rd(pss_pkg::ADDR_SHUTDOWN, 32'h00);
    rd(pss_pkg::ADDR_RESTART, 32'h00);
    rd(pss_pkg::ADDR_STEERING, 32'h01);
    rd(pss_pkg::ADDR_MODE, 32'h00);
    rd(pss_pkg::ADDR_IRQ_STAT, 32'h00);
    rd(pss_pkg::ADDR_IRQ_MASK, 32'h00);
    rd(12'h018, 32'h0, 1'b1);
    wr(pss_pkg::ADDR_STEERING, 32'hff);
    rd(pss_pkg::ADDR_STEERING, 32'h1f);
    pins(pd, po, 1'b0);
    $display("test reset done");
    // Full bridge forward: a held active, d follows the idle waveform
    wr(pss_pkg::ADDR_MODE, 32'h1c);
    wr(pss_pkg::ADDR_RESTART, 32'h80);
    for (int s = 1; s < 8; s++)
      for (int k = 0; k < 3; k++)
      begin
        wr(pss_pkg::ADDR_SHUTDOWN, 32'((s << 4) | 1));
        overload <= (k == 0);
        cmp2_in <= (k == 1);
        ext_irq_pin <= (k != 2);
        idle(10);
        pins(s[k] ? 4'b1010 : 4'b0001, 4'h0, 1'b0);
        rd(pss_pkg::ADDR_SHUTDOWN, 32'((s << 4) | 1) | (s[k] ? 32'h80 : 32'h0));
        overload <= 1'b0;
        cmp2_in <= 1'b0;
        ext_irq_pin <= 1'b1;
        idle(10);
        pins(4'b0001, 4'h0, 1'b0);
        rd(pss_pkg::ADDR_SHUTDOWN, 32'((s << 4) | 1));
      end
    rd(pss_pkg::ADDR_IRQ_STAT, 32'h3);
    rd(pss_pkg::ADDR_IRQ_STAT, 32'h0);
    $display("test sources done");
    // Manual restart with tri-stated pins and the entry interrupt unmasked
    wr(pss_pkg::ADDR_RESTART, 32'h00);
    wr(pss_pkg::ADDR_IRQ_MASK, 32'h1);
    wr(pss_pkg::ADDR_SHUTDOWN, 32'h1e);
    overload <= 1'b1;
    idle(10);
    pins(4'h0, 4'hf, 1'b1, 4'h0);
    overload <= 1'b0;
    idle(10);
    pins(4'h0, 4'hf, 1'b1, 4'h0);
    rd(pss_pkg::ADDR_SHUTDOWN, 32'h9e);
    rd(pss_pkg::ADDR_IRQ_STAT, 32'h1);
    wr(pss_pkg::ADDR_SHUTDOWN, 32'h1e);
    idle(4);
    pins(4'b0001, 4'h0, 1'b0);
    $display("test manual restart done");
    // Comparator sync: shutdown entry and exit both wait for a Timer1 tick
    wr(pss_pkg::ADDR_MODE, 32'h5c);
    wr(pss_pkg::ADDR_RESTART, 32'h80);
    wr(pss_pkg::ADDR_SHUTDOWN, 32'h11);
    overload <= 1'b1;
    idle(10);
    pins(4'b0001, 4'h0, 1'b0);
    timer1_tick <= 1'b1;
    @(posedge sys_clk);
    timer1_tick <= 1'b0;
    idle(4);
    pins(4'b1010, 4'h0, 1'b1);
    overload <= 1'b0;
    idle(10);
    pins(4'b1010, 4'h0, 1'b1);
    timer1_tick <= 1'b1;
    @(posedge sys_clk);
    timer1_tick <= 1'b0;
    idle(4);
    pins(4'b0001, 4'h0, 1'b1);
    rd(pss_pkg::ADDR_IRQ_STAT, 32'h3);
    $display("test comparator sync done");
    // Single output steered to a: rising edges wait the dead count
    wr(pss_pkg::ADDR_MODE, 32'h0c);
    wr(pss_pkg::ADDR_STEERING, 32'h01);
    for (int j = 0; j < 2; j++)
    begin
      d = (j == 0) ? 0 : int'(rnd() % 128);
      wr(pss_pkg::ADDR_RESTART, 32'(d));
      idle(3);
      edges(1'b1);
      cmp("rise delay", 40'(d + 3), 40'(n));
      edges(1'b0);
      cmp("fall delay", 40'd3, 40'(n));
    end
    wr(pss_pkg::ADDR_RESTART, 32'h00);
    wr(pss_pkg::ADDR_MODE, 32'h0e);
    idle(3);
    pins(4'h1, {po[3:1], 1'b0}, 1'b0, 4'h1);
    $display("test dead delay done");
    // Steering: synced update waits for a period start
    wr(pss_pkg::ADDR_MODE, 32'h0c);
    wr(pss_pkg::ADDR_STEERING, 32'h1f);
    idle(3);
    pins({pd[3:1], 1'b0}, {po[3:1], 1'b0}, 1'b0);
    period_start <= 1'b1;
    @(posedge sys_clk);
    period_start <= 1'b0;
    idle(3);
    pins(4'h0, 4'h0, 1'b0);
    wr(pss_pkg::ADDR_STEERING, 32'h04);
    idle(3);
    pins({pd[3], 1'b0, pd[1:0]}, {po[3], 1'b0, po[1:0]}, 1'b0);
    wr(pss_pkg::ADDR_MODE, 32'h2c);
    idle(3);
    pins({pd[3:2], 2'b10}, {po[3:2], 2'b00}, 1'b0);
    wr(pss_pkg::ADDR_MODE, 32'h3c);
    idle(3);
    pins(4'b0100, 4'h0, 1'b0);
    wr(pss_pkg::ADDR_MODE, 32'h04);
    idle(3);
    pins(pd, po, 1'b0);
    $display("test steering done");
    finish_test();
  end
endmodule // tb
